// >>> core/spc_sdram_if.v
// device-side pin command and data interface of a two-bank sdram
//
// Summary of operation
// [RL1] all pins captured at link clock rise, except cke, watched as a level in low power
// [RL2] burst counter and outputs advance on link clock
// [RL3] cke low suspends from next cycle, freezes state
// [RL4] low-power entry only with both banks idle
// [RL5] low power: cke asynchronous, input buffers disabled
// [RL6] bank bit selects the single target bank
// [RL7] activate latches row from eleven low lines
// [RL8] column from eight low lines, a10 autoprecharge
// [RL9] precharge with a10 high closes both banks
// [RL10] mode register set loads op-code from address
// [RL11] chip select high masks every command
// [RL12] ras low cas high: we picks activate/precharge
// [RL13] ras high cas low: we picks read/write
// [RL14] read has we high, write we low
// [RL15] write byte mask discards byte, buffer off
// [RL16] read byte mask suppresses output two clocks later
// [RL17] upper mask bits 15:8, lower mask 7:0
// [RL18] sixteen-bit data moves on link clock edges
// [RL19] controller sends nop when idle
`timescale 1ns/1ps
`include "spc_defs.vh"
module spc_sdram_if #(
	parameter DATA_W = 16,
	parameter ADDR_W = 12
) (
	input wire clock_in,
	input wire reset_in,
	input wire sdram_clk_in,
	input wire cke_in,
	input wire chip_select_n_in,
	input wire row_strobe_n_in,
	input wire col_strobe_n_in,
	input wire write_enable_n_in,
	input wire [ADDR_W-1:0] addr_in,
	input wire upper_byte_mask_in,
	input wire lower_byte_mask_in,
	input wire [DATA_W-1:0] data_bus_in,
	output reg [DATA_W-1:0] data_bus_out,
	output wire [1:0] data_bus_oe_n_out,
	output reg [19:0] core_addr_out,
	output reg core_rd_out,
	output reg core_wr_out,
	output reg [DATA_W-1:0] core_wdata_out,
	output reg [1:0] core_byte_en_out,
	input wire [DATA_W-1:0] core_rdata_in,
	output wire [1:0] bank_active_out,
	output reg low_power_out,
	output reg self_refresh_out,
	output reg refresh_out,
	output reg [ADDR_W-1:0] mode_opcode_out
);
	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	reg [`SPC_PIN_WIDTH-1:0] s1_r;
	reg [`SPC_PIN_WIDTH-1:0] s2_r;
	reg [`SPC_PIN_WIDTH-1:0] s3_r;
	reg [`SPC_PIN_WIDTH-1:0] pin_r;
	wire [`SPC_PIN_WIDTH-1:0] pin_nxt;
	wire [`SPC_PIN_WIDTH-1:0] pin_raw;

	assign pin_raw = {sdram_clk_in, cke_in, chip_select_n_in, row_strobe_n_in, col_strobe_n_in,
		write_enable_n_in, addr_in, upper_byte_mask_in, lower_byte_mask_in, data_bus_in};
	// a bit changes only once stages two and three agree
	assign pin_nxt = (s2_r & ~(s2_r ^ s3_r)) | (pin_r & (s2_r ^ s3_r));

	// three-flop chain, first stage feeds only the second
	always @(posedge clock_in) begin
		if (reset_in) begin
			s1_r <= {`SPC_PIN_WIDTH{1'b0}};
			s2_r <= {`SPC_PIN_WIDTH{1'b0}};
			s3_r <= {`SPC_PIN_WIDTH{1'b0}};
			pin_r <= {`SPC_PIN_WIDTH{1'b0}};
		end else begin
			s1_r <= pin_raw;
			s2_r <= s1_r;
			s3_r <= s2_r;
			pin_r <= pin_nxt;
		end
	end

	// ----------------------------------------
	// sampled pin fields
	// ----------------------------------------
	wire tick;
	wire cke_s;
	wire cs_n_s;
	wire [2:0] cmd_s;
	wire [ADDR_W-1:0] addr_s;
	wire [1:0] mask_s;
	wire [DATA_W-1:0] data_s;

	assign tick = pin_nxt[35] & ~pin_r[35]; // RL1
	assign cke_s = pin_nxt[34];
	assign cs_n_s = pin_nxt[33];
	assign cmd_s = pin_nxt[32:30];
	assign addr_s = pin_nxt[29:18];
	assign mask_s = pin_nxt[17:16]; // RL17
	assign data_s = pin_nxt[15:0];

	// ----------------------------------------
	// state
	// ----------------------------------------
	reg cke_prev_r;
	reg [1:0] active_r;
	reg [10:0] row_r [0:1];
	reg bank_r;
	reg [7:0] col_r;
	reg [8:0] cnt_r;
	reg ap_r;
	reg wr_burst_r;
	reg rd_beat_r;
	reg [1:0] pipe_v_r;
	reg [DATA_W-1:0] pipe_d_r [0:1];
	reg out_valid_r;
	reg [1:0] mask_d1_r;
	reg [1:0] out_mask_r;

	wire etick;
	wire cmd_ok;
	wire bs;
	wire [8:0] bl;
	wire [7:0] wrap;
	wire [1:0] cl;
	wire is_rw;
	wire both_idle;
	wire pre_hit;

	// state moves only when the internal clock runs
	assign etick = tick & cke_prev_r & ~low_power_out; // RL3 RL5
	assign cmd_ok = ~cs_n_s; // RL11
	assign bs = addr_s[`SPC_BANK_BIT]; // RL6
	assign both_idle = ~active_r[0] & ~active_r[1];
	assign bank_active_out = active_r;
	assign cl = mode_opcode_out[`SPC_MODE_CL_LSB+1:`SPC_MODE_CL_LSB];

	// burst length from mode op-code, full page is 256
	assign bl = (mode_opcode_out[`SPC_MODE_BL_MSB:0] == 3'h1) ? 9'h002 :
		(mode_opcode_out[`SPC_MODE_BL_MSB:0] == 3'h2) ? 9'h004 :
		(mode_opcode_out[`SPC_MODE_BL_MSB:0] == 3'h3) ? 9'h008 :
		(mode_opcode_out[`SPC_MODE_BL_MSB:0] == 3'h7) ? 9'h100 : 9'h001;
	assign wrap = bl[7:0] - 8'h01;

	// column access to an open bank only
	assign is_rw = cmd_ok & ((cmd_s == `SPC_CMD_RD) | (cmd_s == `SPC_CMD_WR)) & active_r[bs]; // RL13 RL14
	// precharge that hits the bank owning the burst
	assign pre_hit = cmd_ok & (cmd_s == `SPC_CMD_PRE) & (addr_s[`SPC_AUTOPRE_BIT] | (bs == bank_r));

	// ----------------------------------------
	// beat selection for the core
	// ----------------------------------------
	reg beat;
	reg beat_wr;
	reg [7:0] beat_col;
	reg beat_bank;
	reg [7:0] col_base;

	always @* begin
		beat = 1'b0;
		beat_wr = 1'b0;
		beat_col = col_r;
		beat_bank = bank_r;
		col_base = addr_s[`SPC_COL_MSB:0]; // RL8
		if (is_rw) begin
			beat = 1'b1;
			beat_wr = (cmd_s == `SPC_CMD_WR); // RL14
			beat_col = col_base;
			beat_bank = bs;
		end else if (cnt_r != 9'h000) begin
			beat = 1'b1;
			beat_wr = wr_burst_r;
		end
	end

	// ----------------------------------------
	// command decode, banks and burst counter
	// ----------------------------------------
	integer i;
	always @(posedge clock_in) begin
		if (reset_in) begin
			active_r <= 2'h0;
			bank_r <= 1'b0;
			col_r <= 8'h00;
			cnt_r <= 9'h000;
			ap_r <= 1'b0;
			wr_burst_r <= 1'b0;
			mode_opcode_out <= `SPC_MODE_RESET;
			refresh_out <= 1'b0;
			for (i = 0; i < 2; i = i + 1) begin
				row_r[i] <= 11'h000;
			end
		end else begin
			refresh_out <= 1'b0;
			if (etick) begin
				if (cmd_ok && cmd_s == `SPC_CMD_ACT) begin // RL12
					active_r[bs] <= 1'b1; // RL6
					row_r[bs] <= addr_s[`SPC_ROW_MSB:0]; // RL7
				end
				if (cmd_ok && cmd_s == `SPC_CMD_PRE) begin // RL12
					if (addr_s[`SPC_AUTOPRE_BIT]) begin
						active_r <= 2'h0; // RL9
					end else begin
						active_r[bs] <= 1'b0; // RL9
					end
				end
				if (cmd_ok && cmd_s == `SPC_CMD_MRS && both_idle) begin
					mode_opcode_out <= addr_s; // RL10
				end
				if (cmd_ok && cmd_s == `SPC_CMD_REF && cke_s && both_idle) begin
					refresh_out <= 1'b1;
				end
				if (is_rw) begin
					bank_r <= bs;
					ap_r <= addr_s[`SPC_AUTOPRE_BIT]; // RL8
					wr_burst_r <= (cmd_s == `SPC_CMD_WR);
					cnt_r <= bl - 9'h001;
					col_r <= (col_base & ~wrap) | ((col_base + 8'h01) & wrap); // RL2
					if (bl == 9'h001 && addr_s[`SPC_AUTOPRE_BIT]) begin
						active_r[bs] <= 1'b0;
					end
				end else if (cnt_r != 9'h000) begin
					if ((cmd_ok && cmd_s == `SPC_CMD_BST) || pre_hit) begin
						cnt_r <= 9'h000;
					end else begin
						cnt_r <= cnt_r - 9'h001; // RL2
						col_r <= (col_r & ~wrap) | ((col_r + 8'h01) & wrap);
						if (cnt_r == 9'h001 && ap_r) begin
							active_r[bank_r] <= 1'b0;
						end
					end
				end
			end
		end
	end

	// ----------------------------------------
	// core access strobes
	// ----------------------------------------
	always @(posedge clock_in) begin
		if (reset_in) begin
			core_addr_out <= 20'h00000;
			core_rd_out <= 1'b0;
			core_wr_out <= 1'b0;
			core_wdata_out <= {DATA_W{1'b0}};
			core_byte_en_out <= 2'h0;
		end else begin
			core_rd_out <= 1'b0;
			core_wr_out <= 1'b0;
			if (etick && beat) begin
				core_addr_out <= {beat_bank, row_r[beat_bank], beat_col}; // RL6
				core_rd_out <= ~beat_wr;
				core_wr_out <= beat_wr & (mask_s != 2'h3);
				core_wdata_out <= data_s; // RL18
				core_byte_en_out <= ~mask_s; // RL15 RL17
			end
		end
	end

	// ----------------------------------------
	// read latency pipeline and data output
	// ----------------------------------------
	always @(posedge clock_in) begin
		if (reset_in) begin
			rd_beat_r <= 1'b0;
			pipe_v_r <= 2'h0;
			pipe_d_r[0] <= {DATA_W{1'b0}};
			pipe_d_r[1] <= {DATA_W{1'b0}};
			out_valid_r <= 1'b0;
			data_bus_out <= {DATA_W{1'b0}};
			mask_d1_r <= 2'h3;
			out_mask_r <= 2'h3;
		end else if (etick) begin // RL2 RL3
			rd_beat_r <= beat & ~beat_wr;
			pipe_v_r <= {pipe_v_r[0], rd_beat_r};
			pipe_d_r[0] <= core_rdata_in;
			pipe_d_r[1] <= pipe_d_r[0];
			mask_d1_r <= mask_s;
			out_mask_r <= mask_d1_r; // RL16
			if (cl == 2'h1) begin
				out_valid_r <= rd_beat_r;
				data_bus_out <= core_rdata_in; // RL18
			end else if (cl == 2'h2) begin
				out_valid_r <= pipe_v_r[0];
				data_bus_out <= pipe_d_r[0];
			end else begin
				out_valid_r <= pipe_v_r[1];
				data_bus_out <= pipe_d_r[1];
			end
		end
	end

	// byte drivers on only for unmasked read data
	assign data_bus_oe_n_out = ~({2{out_valid_r}} & ~out_mask_r); // RL15 RL16 RL17

	// ----------------------------------------
	// clock enable, power down and self refresh
	// ----------------------------------------
	always @(posedge clock_in) begin
		if (reset_in) begin
			cke_prev_r <= 1'b1;
			low_power_out <= 1'b0;
			self_refresh_out <= 1'b0;
		end else if (low_power_out) begin
			// cke watched as a level, link clock ignored
			if (pin_r[34]) begin // RL5
				low_power_out <= 1'b0;
				self_refresh_out <= 1'b0;
				cke_prev_r <= 1'b1;
			end
		end else if (tick) begin
			cke_prev_r <= cke_s; // RL3
			if (cke_prev_r && !cke_s && both_idle && cnt_r == 9'h000) begin // RL4
				if (cmd_ok && cmd_s == `SPC_CMD_REF) begin
					low_power_out <= 1'b1;
					self_refresh_out <= 1'b1;
				end else if (!cmd_ok || cmd_s == `SPC_CMD_NOP) begin
					low_power_out <= 1'b1;
				end
			end
		end
	end
endmodule // spc_sdram_if

// >>> pkg/spc_defs.vh
// constants for the sdram pin command interface
`ifndef SPC_DEFS_VH
`define SPC_DEFS_VH
// ----------------------------------------
// command codes {ras_n, cas_n, we_n}
// ----------------------------------------
`define SPC_CMD_MRS 3'h0
`define SPC_CMD_REF 3'h1
`define SPC_CMD_PRE 3'h2
`define SPC_CMD_ACT 3'h3
`define SPC_CMD_WR 3'h4
`define SPC_CMD_RD 3'h5
`define SPC_CMD_BST 3'h6
`define SPC_CMD_NOP 3'h7
// ----------------------------------------
// address field positions
// ----------------------------------------
`define SPC_BANK_BIT 11
`define SPC_AUTOPRE_BIT 10
`define SPC_ROW_MSB 10
`define SPC_COL_MSB 7
// ----------------------------------------
// mode op-code fields and reset value
// ----------------------------------------
`define SPC_MODE_BL_MSB 2
`define SPC_MODE_CL_LSB 4
`define SPC_MODE_CL_MSB 6
`define SPC_MODE_RESET 12'h020
// ----------------------------------------
// pin sampling
// ----------------------------------------
`define SPC_PIN_WIDTH 36
`endif

// >>> verification/spc_chk_sva.sv
// port checker for the pin command interface
`timescale 1ns/1ps
module spc_chk (
	input wire clock_in,
	input wire reset_in,
	input wire core_rd_out,
	input wire core_wr_out,
	input wire [1:0] core_byte_en_out,
	input wire [1:0] bank_active_out,
	input wire low_power_out,
	input wire self_refresh_out,
	input wire [11:0] mode_opcode_out
);
	default clocking cb @(posedge clock_in);
	endclocking
	default disable iff (reset_in);
	// one beat pulse, then quiet for the next four clock_in cycles
	sequence s_rd;
		core_rd_out ##1 !core_rd_out [*4];
	endsequence
	sequence s_wr;
		core_wr_out ##1 !core_wr_out [*4];
	endsequence
	rd_beat_a: assert property (core_rd_out |-> s_rd) else $error("rd pulse");
	wr_beat_a: assert property (core_wr_out |-> s_wr) else $error("wr pulse");
	wr_mask_a: assert property (core_wr_out |-> core_byte_en_out != 2'b00) else $error("masked wr");
	rw_excl_a: assert property (!(core_rd_out && core_wr_out)) else $error("rd with wr");
	lp_quiet_a: assert property (low_power_out |-> !core_rd_out && !core_wr_out) else $error("lp beat");
	sr_lp_a: assert property (self_refresh_out |-> low_power_out) else $error("sr flag");
	lp_idle_a: assert property (low_power_out |-> bank_active_out == 2'b00) else $error("lp busy");
	mode_idle_a: assert property ($changed(mode_opcode_out) |-> $past(bank_active_out) == 2'b00)
		else $error("mode busy");
endmodule // spc_chk
bind spc_sdram_if spc_chk i_spc_chk (.clock_in(clock_in), .reset_in(reset_in), .core_rd_out(core_rd_out),
	.core_wr_out(core_wr_out), .core_byte_en_out(core_byte_en_out), .bank_active_out(bank_active_out),
	.low_power_out(low_power_out), .self_refresh_out(self_refresh_out), .mode_opcode_out(mode_opcode_out));

// >>> verification/spc_ctrl.sv
// memory controller model driving the device pins
`timescale 1ns/1ps
`include "spc_defs.vh"
module spc_ctrl (
	input wire clock_in,
	output logic link_clk_out,
	output logic [34:0] pins_out
);
	logic [34:0] cmd_q[$];
	logic [34:0] c;
	logic seen_r;
	// free link clock, phase unrelated to clock_in
	initial begin
		link_clk_out = 1'b0;
		seen_r = 1'b0;
		pins_out = {2'b10, `SPC_CMD_NOP, 30'h0};
		#137;
		forever #200 link_clk_out = ~link_clk_out;
	end
	// new pins after a link fall, held over the rise
	always @(posedge clock_in) begin
		seen_r <= link_clk_out;
		if (seen_r && !link_clk_out) begin
			c = cmd_q.size() > 0 ? cmd_q.pop_front() : {2'b10, `SPC_CMD_NOP, 30'h0};
			pins_out <= c[32:30] == `SPC_CMD_WR ? c : {c[34:16], ~pins_out[15:0]};
		end
	end
endmodule // spc_ctrl

// >>> verification/tb_top.sv
// self-checking bench for the pin command interface
`timescale 1ns/1ps
`include "spc_defs.vh"
module tb_top;
	logic clock_in, reset_in, lk, rd, wr, lp, sr, b, rf;
	logic [34:0] p;
	logic [15:0] rdat, dq, wd;
	logic [19:0] ca;
	logic [1:0] oe, be, bk, poe;
	logic [11:0] mode, op;
	logic [31:0] r;
	logic [39:0] exq[$];
	logic [10:0] row;
	int n_fail, n_compared, m;
	spc_ctrl i_spc_ctrl (.clock_in(clock_in), .link_clk_out(lk), .pins_out(p));
	spc_sdram_if i_spc_sdram_if (.clock_in(clock_in), .reset_in(reset_in), .sdram_clk_in(lk), .cke_in(p[34]),
		.chip_select_n_in(p[33]), .row_strobe_n_in(p[32]), .col_strobe_n_in(p[31]), .write_enable_n_in(p[30]),
		.addr_in(p[29:18]), .upper_byte_mask_in(p[17]), .lower_byte_mask_in(p[16]), .data_bus_in(p[15:0]),
		.data_bus_out(dq), .data_bus_oe_n_out(oe), .core_addr_out(ca), .core_rd_out(rd), .core_wr_out(wr),
		.core_wdata_out(wd), .core_byte_en_out(be), .core_rdata_in(rdat), .bank_active_out(bk),
		.low_power_out(lp), .self_refresh_out(sr), .refresh_out(rf), .mode_opcode_out(mode));
	// clock
	always #25 clock_in = ~clock_in;
	function logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction
	function logic [15:0] bm(input logic [1:0] k);
		return ~{{8{k[1]}}, {8{k[0]}}};
	endfunction
	task chk(input string n, input logic [39:0] e, input logic [39:0] s);
		n_compared++;
		if (s !== e) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask
	task go(input logic [1:0] k, input logic [2:0] c, input logic [11:0] a, input logic [1:0] mk,
		input logic [15:0] d);
		i_spc_ctrl.cmd_q.push_back({k, c, a, mk, d});
	endtask
	task settle(input int n);
		while (i_spc_ctrl.cmd_q.size() > 0)
			@(posedge clock_in);
		repeat (n) @(posedge clock_in);
	endtask
	task see(input logic [39:0] v);
		if (exq.size() == 0)
			chk("surplus", 40'h0, v);
		else
			chk("result", exq.pop_front(), v);
	endtask
	task give_verdict;
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// core memory answers, results matched to notes
	always @(posedge clock_in) begin
		poe <= oe;
		rdat <= ca[15:0] ^ 16'hC3A5;
		if (wr === 1'b1)
			see({2'b01, ca, be, wd & bm(~be)});
		if (rd === 1'b1)
			see({2'b10, ca, 18'h0});
		if (oe !== 2'b11 && poe === 2'b11)
			see({2'b11, 20'h0, oe, dq & bm(oe)});
		if (rf === 1'b1)
			see(40'h1);
	end
	// watchdog
	initial begin
		#100000;
		n_fail++;
		give_verdict;
	end
	// main sequence
	initial begin
		clock_in = 1'b0;
		reset_in = 1'b1;
		rdat = 16'h0;
		poe = 2'b11;
		n_fail = 0;
		n_compared = 0;
		r = 32'd97106;
		repeat (5) @(posedge clock_in);
		reset_in <= 1'b0;
		// mode load with random spare bits
		r = xs(r);
		op = {r[4:0], 3'b010, r[5], 3'b000};
		go(2'b10, `SPC_CMD_MRS, op, 2'b00, 16'h0);
		settle(24);
		chk("mode", {28'h0, op}, {28'h0, mode});
		// deselected activate, then a real one
		r = xs(r);
		b = r[11];
		row = r[10:0];
		go(2'b11, `SPC_CMD_ACT, {~b, row}, 2'b00, 16'h0);
		go(2'b10, `SPC_CMD_ACT, {b, row}, 2'b00, 16'h0);
		settle(24);
		chk("banks", {38'h0, b, ~b}, {38'h0, bk});
		// writes under every mask, third closes bank
		for (m = 0; m < 4; m++) begin
			r = xs(r);
			go(2'b10, `SPC_CMD_WR, {b, m == 2, 2'b00, r[7:0]}, m[1:0], r[23:8]);
			if (m < 3)
				exq.push_back({2'b01, b, row, r[7:0], ~m[1:0], r[23:8] & bm(m[1:0])});
		end
		settle(24);
		chk("banks", 40'h0, {38'h0, bk});
		// reads, mask one tick after the command
		go(2'b10, `SPC_CMD_ACT, {b, row}, 2'b00, 16'h0);
		for (m = 0; m < 4; m++) begin
			r = xs(r);
			go(2'b10, `SPC_CMD_RD, {b, 3'b000, r[7:0]}, 2'b00, 16'h0);
			go(2'b10, `SPC_CMD_NOP, 12'h0, m[1:0], 16'h0);
			go(2'b10, `SPC_CMD_NOP, 12'h0, 2'b00, 16'h0);
			go(2'b10, `SPC_CMD_NOP, 12'h0, 2'b00, 16'h0);
			exq.push_back({2'b10, b, row, r[7:0], 18'h0});
			if (m < 3)
				exq.push_back({2'b11, 20'h0, m[1:0], ({row[7:0], r[7:0]} ^ 16'hC3A5) & bm(m[1:0])});
		end
		// both open, close one, then all
		go(2'b10, `SPC_CMD_ACT, {~b, row}, 2'b00, 16'h0);
		go(2'b10, `SPC_CMD_PRE, {b, 11'h0}, 2'b00, 16'h0);
		settle(24);
		chk("banks", {38'h0, ~b, b}, {38'h0, bk});
		go(2'b10, `SPC_CMD_PRE, {b, 11'h400}, 2'b00, 16'h0);
		settle(24);
		chk("banks", 40'h0, {38'h0, bk});
		// auto refresh, then write burst of two with autoprecharge
		exq.push_back(40'h1);
		go(2'b10, `SPC_CMD_REF, 12'h0, 2'b00, 16'h0);
		go(2'b10, `SPC_CMD_MRS, 12'h011, 2'b00, 16'h0);
		go(2'b10, `SPC_CMD_ACT, {b, row}, 2'b00, 16'h0);
		r = xs(r);
		go(2'b10, `SPC_CMD_WR, {b, 3'b100, r[7:0]}, 2'b00, r[23:8]);
		go(2'b10, `SPC_CMD_NOP, 12'h0, 2'b01, 16'h0);
		exq.push_back({2'b01, b, row, r[7:0], 2'b11, r[23:8]});
		exq.push_back({2'b01, b, row, r[7:1], ~r[0], 2'b10, ~r[23:8] & 16'hFF00});
		settle(24);
		chk("banks", 40'h0, {38'h0, bk});
		chk("mode", 40'h011, {28'h0, mode});
		// read burst of two at latency one, second beat masked
		go(2'b10, `SPC_CMD_ACT, {b, row}, 2'b00, 16'h0);
		go(2'b10, `SPC_CMD_RD, {b, 3'b000, r[15:8]}, 2'b00, 16'h0);
		go(2'b10, `SPC_CMD_NOP, 12'h0, 2'b11, 16'h0);
		go(2'b10, `SPC_CMD_PRE, 12'h400, 2'b00, 16'h0);
		exq.push_back({2'b10, b, row, r[15:8], 18'h0});
		exq.push_back({2'b10, b, row, r[15:9], ~r[8], 18'h0});
		exq.push_back({2'b11, 20'h0, 2'b00, {row[7:0], r[15:8]} ^ 16'hC3A5});
		settle(24);
		chk("banks", 40'h0, {38'h0, bk});
		// power down, activate ignored meanwhile
		go(2'b00, `SPC_CMD_NOP, 12'h0, 2'b00, 16'h0);
		go(2'b00, `SPC_CMD_ACT, {b, row}, 2'b00, 16'h0);
		go(2'b00, `SPC_CMD_NOP, 12'h0, 2'b00, 16'h0);
		settle(2);
		chk("power down", 40'h1, {37'h0, bk, lp});
		// wake first, then self refresh entry and exit
		go(2'b10, `SPC_CMD_NOP, 12'h0, 2'b00, 16'h0);
		go(2'b00, `SPC_CMD_REF, 12'h0, 2'b00, 16'h0);
		go(2'b00, `SPC_CMD_NOP, 12'h0, 2'b00, 16'h0);
		settle(2);
		chk("self refresh", 40'h3, {38'h0, sr, lp});
		settle(24);
		chk("exit", 40'h0, {36'h0, bk, sr, lp});
		chk("pending", 40'h0, 40'(exq.size()));
		give_verdict;
	end
endmodule // tb_top
